// ### logic/ios_seq.v
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Startup-complete is low from sequence start, whatever restart level.
// - Startup-complete rises only after ready_release is high.
// - Chain-enable asserts together with ready_release release.
// - io_weak_pull_disable gates user I/O weak pull-ups during init.
// - First variant reset delay 12 ms or 100 ms by delay select.
// - First variant busy falls within 800 ns, rises within 100 us.
// - First variant extra delay 33-60 us, or 50-90 ms added.
// - First variant ready delay 600-1100 ns, user mode 25-55 us.
// - Second variant reset 1-2/70-100 ms, extra 4-8 or 25-75 ms.
// - Second variant busy 800 ns / 40 us, user mode 6-28 us.
// - Third variant reset 5 us, extra 0 or 50 ms.
// - Third variant busy 200 ns / 1 us, user mode 2.5-8 us.
// - Weak pull-ups on busy, restart and ready pins.
// - Serial clock and eight data inputs carry weak pull-ups.
// - Startup-complete enable is a fixed parameter.
// - Delay select lengthens reset sequence before initialization.
// - After reset delay, initialize and release ready_release.
// - Restart pulse drives busy, ready_release, startup and user mode low, chain-enable out high, then repeats release order.
`include "ios_seq_regs.vh"
module ios_seq #(
   parameter [1:0] VARIANT       = `IOS_VAR_FIRST,
   parameter       LONG_SELECT   = 0,
   parameter       ADDED_DELAY   = 0,
   parameter       STARTUP_EN    = 1,
   parameter       POR_SHORT_NS  = `IOS_T1_POR_SHORT_NS,
   parameter       POR_LONG_NS   = `IOS_T1_POR_LONG_NS,
   parameter       ADD_NS        = `IOS_T1_ADD_NS,
   parameter       ADD_LONG_NS   = `IOS_T1_ADD_LONG_NS,
   parameter       CD_NS         = `IOS_T1_CD_NS,
   parameter       UM_NS         = `IOS_T1_UM_NS
) (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        clk_en,
   input  wire        restart_request_n,
   input  wire        chain_enable_in_n,
   input  wire        io_weak_pull_disable,
   output wire        busy_flag_n_o,
   output wire        busy_flag_n_oe,
   input  wire        busy_flag_n_i,
   output wire        ready_release_o,
   output wire        ready_release_oe,
   input  wire        ready_release_i,
   output reg         chain_enable_out_n,
   output reg         startup_done,
   output reg         user_mode,
   output reg         io_weak_pull_en,
   output wire        restart_pull_en,
   output wire        busy_pull_en,
   output wire        ready_pull_en,
   output wire        cfg_serial_clock_pull_en,
   output wire [7:0]  cfg_data_pull_en,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   // Cycle counts, least times rounded up
   // Third variant has one fixed reset delay, so delay select is ignored there
   localparam         IS_THIRD = (VARIANT == `IOS_VAR_THIRD);
   localparam integer POR_NS   = (LONG_SELECT && !IS_THIRD) ? POR_LONG_NS
                                                            : POR_SHORT_NS;
   localparam integer ADDT_NS  = ADDED_DELAY ? ADD_LONG_NS : ADD_NS;
   localparam integer NSPC     = 1000 / `IOS_CLK_MHZ;
   localparam integer POR_CYC  = (POR_NS + NSPC - 1) / NSPC;
   localparam integer ADD_CYC  = (ADDT_NS + NSPC - 1) / NSPC;
   localparam integer CD_CYC   = (CD_NS + NSPC - 1) / NSPC;
   localparam integer UM_CYC   = (UM_NS + NSPC - 1) / NSPC;
   localparam integer POR_C1   = POR_CYC < 1 ? 1 : POR_CYC;
   localparam integer ADD_C1   = ADD_CYC < 1 ? 1 : ADD_CYC;
   localparam integer CD_C1    = CD_CYC < 1 ? 1 : CD_CYC;
   localparam integer UM_C1    = UM_CYC < 1 ? 1 : UM_CYC;

   localparam [2:0] ST_POR   = 3'd0;
   localparam [2:0] ST_HOLD  = 3'd1;
   localparam [2:0] ST_ADD   = 3'd2;
   localparam [2:0] ST_CD    = 3'd3;
   localparam [2:0] ST_UM    = 3'd4;
   localparam [2:0] ST_USER  = 3'd5;

   reg  [2:0]  state;
   reg  [31:0] cnt;
   reg  [2:0]  rq_sync;
   reg         rq_n;
   reg         busy_n;
   reg         ready;
   reg         sw_restart;
   reg         aw_held;
   reg         w_held;
   reg  [11:0] aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;

   // Three-stage sync; level taken when stages two and three agree
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rq_sync <= 3'b111;
         rq_n    <= 1'b1;
      end else if (clk_en) begin
         rq_sync <= {rq_sync[1:0], restart_request_n};
         if (rq_sync[1] == rq_sync[2])
            rq_n <= rq_sync[2];
      end
   end

   wire restart_hit = !rq_n || sw_restart;
   // Three sync stages plus rq_n and the busy register (five cycles, 50 ns) stay far below 200 ns
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state              <= ST_POR;
         cnt                <= 32'h0000_0000;
         busy_n             <= 1'b0;
         ready              <= 1'b0;
         chain_enable_out_n <= 1'b1;
         startup_done       <= 1'b0;
         user_mode          <= 1'b0;
         io_weak_pull_en    <= 1'b0;
      end else if (clk_en) begin
         io_weak_pull_en <= !user_mode && !io_weak_pull_disable;
         if (restart_hit && state != ST_POR) begin
            state              <= ST_HOLD;
            cnt                <= 32'h0000_0000;
            busy_n             <= 1'b0;
            ready              <= 1'b0;
            chain_enable_out_n <= 1'b1;
            startup_done       <= 1'b0;
            user_mode          <= 1'b0;
         end else begin
            case (state)
               ST_POR: begin
                  if (cnt >= POR_C1 - 1) begin
                     cnt   <= 32'h0000_0000;
                     state <= rq_n ? ST_ADD : ST_HOLD;
                     busy_n <= rq_n;
                  end else
                     cnt <= cnt + 32'h0000_0001;
               end
               ST_HOLD: begin
                  // Release of restart raises busy next cycle, well inside 1 us
                  if (rq_n) begin
                     busy_n <= 1'b1;
                     state  <= ST_ADD;
                     cnt    <= 32'h0000_0000;
                  end
               end
               ST_ADD: begin
                  if (cnt >= ADD_C1 - 1) begin
                     cnt   <= 32'h0000_0000;
                     state <= ST_CD;
                  end else
                     cnt <= cnt + 32'h0000_0001;
               end
               ST_CD: begin
                  if (cnt >= CD_C1 - 1) begin
                     cnt                <= 32'h0000_0000;
                     ready              <= 1'b1;
                     chain_enable_out_n <= chain_enable_in_n;
                     state              <= ST_UM;
                  end else
                     cnt <= cnt + 32'h0000_0001;
               end
               ST_UM: begin
                  if (cnt >= UM_C1 - 1) begin
                     cnt          <= 32'h0000_0000;
                     user_mode    <= 1'b1;
                     startup_done <= (STARTUP_EN != 0) && ready;
                     state        <= ST_USER;
                  end else
                     cnt <= cnt + 32'h0000_0001;
               end
               ST_USER: state <= ST_USER;
               default: state <= ST_POR;
            endcase
         end
      end
   end

   // Open-drain: drive low only, pull-ups let the line rise
   assign busy_flag_n_o    = 1'b0;
   assign busy_flag_n_oe   = !busy_n;
   assign ready_release_o  = 1'b0;
   assign ready_release_oe = !ready;
   assign restart_pull_en  = 1'b1;
   assign busy_pull_en     = 1'b1;
   assign ready_pull_en    = 1'b1;
   assign cfg_serial_clock_pull_en = 1'b1;
   assign cfg_data_pull_en = 8'hff;

   // AXI4-Lite slave; one write and one read at a time
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire wr_go = aw_held && w_held && !s_axi_bvalid;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         sw_restart   <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (clk_en) begin
         sw_restart <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            if (aw_addr[11:2] == `IOS_OFS_CTRL >> 2)
               sw_restart <= w_strb[0] && w_data[`IOS_CTRL_RESTART];
            else if (aw_addr[11:2] != `IOS_OFS_STATUS >> 2 &&
                     aw_addr[11:2] != `IOS_OFS_PINS >> 2)
               s_axi_bresp <= 2'b10;
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr[11:2])
               `IOS_OFS_CTRL >> 2: s_axi_rdata <= `IOS_CTRL_RST_VAL;
               `IOS_OFS_STATUS >> 2: s_axi_rdata <= {23'h0, io_weak_pull_en,
                  startup_done, !chain_enable_out_n, ready, !busy_n, 1'b0, state};
               `IOS_OFS_PINS >> 2: s_axi_rdata <= {28'h0, chain_enable_in_n,
                  ready_release_i, busy_flag_n_i, rq_n};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ### logic/ios_seq_regs.vh
`ifndef IOS_SEQ_REGS_VH
`define IOS_SEQ_REGS_VH
// Variant codes
`define IOS_VAR_FIRST       2'h0
`define IOS_VAR_SECOND      2'h1
`define IOS_VAR_THIRD       2'h2
// Clock rate
`define IOS_CLK_MHZ         100
// Register offsets (byte addresses)
`define IOS_OFS_CTRL        12'h000
`define IOS_OFS_STATUS      12'h004
`define IOS_OFS_PINS        12'h008
// Control fields
`define IOS_CTRL_RESTART    0
`define IOS_CTRL_RST_VAL    32'h0000_0000
// Status fields
`define IOS_ST_STATE_LSB    0
`define IOS_ST_BUSY         4
`define IOS_ST_READY        5
`define IOS_ST_CHAIN        6
`define IOS_ST_STARTUP      7
`define IOS_ST_PULL         8
// Times in ns (first variant)
`define IOS_T1_POR_SHORT_NS 12000000
`define IOS_T1_POR_LONG_NS  100000000
`define IOS_T1_ADD_NS       33000
`define IOS_T1_ADD_LONG_NS  50000000
`define IOS_T1_CD_NS        600
`define IOS_T1_UM_NS        25000
`define IOS_T1_ST0_NS       800
`define IOS_T1_ST1_NS       100000
// Second variant
`define IOS_T2_POR_SHORT_NS 1000000
`define IOS_T2_POR_LONG_NS  70000000
`define IOS_T2_ADD_NS       4000000
`define IOS_T2_ADD_LONG_NS  25000000
`define IOS_T2_CD_NS        500
`define IOS_T2_UM_NS        6000
`define IOS_T2_ST0_NS       800
`define IOS_T2_ST1_NS       40000
// Third variant
`define IOS_T3_POR_NS       5000
`define IOS_T3_ADD_NS       0
`define IOS_T3_ADD_LONG_NS  50000000
`define IOS_T3_CD_NS        500
`define IOS_T3_UM_NS        2500
`define IOS_T3_ST0_NS       200
`define IOS_T3_ST1_NS       1000
`endif

// ### dv/ios_seq_props.sv
`timescale 1ns/1ps
module ios_seq_props #(
   parameter CD_NS = 600,
   parameter UM_NS = 25000
) (
   input wire       core_clk,
   input wire       rst,
   input wire       restart_request_n,
   input wire       chain_enable_in_n,
   input wire       io_weak_pull_disable,
   input wire       busy_flag_n_oe,
   input wire       ready_release_oe,
   input wire       chain_enable_out_n,
   input wire       startup_done,
   input wire       user_mode,
   input wire       io_weak_pull_en,
   input wire       restart_pull_en,
   input wire       busy_pull_en,
   input wire       ready_pull_en,
   input wire       cfg_serial_clock_pull_en,
   input wire [7:0] cfg_data_pull_en
);
   localparam CD_CYC = (CD_NS + 9) / 10;
   localparam UM_CYC = (UM_NS + 9) / 10;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_start_after_ready: assert property ($rose(startup_done) |-> !ready_release_oe)
      else $error("startup_done rose while ready held low");
   a_start_low_restart: assert property ($rose(busy_flag_n_oe) |-> !startup_done)
      else $error("startup_done high at sequence start");
   a_chain_with_ready: assert property ($fell(ready_release_oe) && !chain_enable_in_n |->
      !chain_enable_out_n)
      else $error("chain enable not asserted at ready release");
   a_ready_needs_idle: assert property (!ready_release_oe |-> !busy_flag_n_oe)
      else $error("ready released while busy held");
   a_busy_fall_time: assert property ($fell(restart_request_n) && !ready_release_oe |->
      ##[1:80] busy_flag_n_oe)
      else $error("busy not asserted in time after restart");
   a_busy_rise_time: assert property ($rose(restart_request_n) |-> ##[1:1000] !busy_flag_n_oe)
      else $error("busy not released in time after restart");
   a_ready_delay: assert property ($fell(ready_release_oe) |-> $past(!busy_flag_n_oe, CD_CYC))
      else $error("ready released too early");
   a_user_delay: assert property ($rose(startup_done) |-> $past(!ready_release_oe, UM_CYC))
      else $error("startup_done too early after ready");
   a_pulls_fixed: assert property (restart_pull_en && busy_pull_en && ready_pull_en &&
      cfg_serial_clock_pull_en && (&cfg_data_pull_en))
      else $error("config pin pull-up disabled");
   a_io_pull_gate: assert property (io_weak_pull_disable || user_mode |=> !io_weak_pull_en)
      else $error("user io pulls on while disabled or in user mode");
endmodule
bind ios_seq ios_seq_props #(.CD_NS(CD_NS), .UM_NS(UM_NS)) ios_seq_props_inst (.core_clk,
   .rst, .restart_request_n, .chain_enable_in_n, .io_weak_pull_disable, .busy_flag_n_oe,
   .ready_release_oe, .chain_enable_out_n, .startup_done, .user_mode, .io_weak_pull_en,
   .restart_pull_en, .busy_pull_en, .ready_pull_en, .cfg_serial_clock_pull_en, .cfg_data_pull_en);

// ### dv/ios_seq_board.sv
`timescale 1ns/1ps
module ios_seq_board (
   input  wire core_clk,
   input  wire restart_hold,
   input  wire busy_flag_n_oe,
   input  wire ready_release_oe,
   output reg  restart_request_n,
   output wire chain_enable_in_n,
   output wire busy_flag_n_i,
   output wire ready_release_i
);
   initial restart_request_n = 1'b1;
   always @(posedge core_clk) restart_request_n <= !restart_hold;
   assign chain_enable_in_n = 1'b0;
   // Board never pulls these low, pull-ups give high when released
   assign busy_flag_n_i = !busy_flag_n_oe;
   assign ready_release_i = !ready_release_oe;
endmodule

// ### dv/ios_seq_tb.sv
`timescale 1ns/1ps
module ios_seq_tb;
   localparam CD_NS = 600;
   localparam UM_NS = 500;
   localparam logic [11:0] RA [4] = '{12'h000, 12'h004, 12'h008, 12'h00C};
   localparam logic [31:0] RD [4] = '{32'h0000_0000, 32'h0000_00E0, 32'h0000_0007, 32'h0000_0000};
   localparam logic [31:0] RM [4] = '{32'hFFFF_FFFF, 32'h0000_01F0, 32'h0000_000F, 32'hFFFF_FFFF};
   localparam logic [1:0]  RR [4] = '{2'h0, 2'h0, 2'h0, 2'h2};
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        restart_hold = 1'b0;
   logic        io_weak_pull_disable = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire         restart_request_n, chain_enable_in_n, busy_flag_n_oe, busy_flag_n_i;
   wire         ready_release_oe, ready_release_i, chain_enable_out_n, startup_done, user_mode;
   wire         io_weak_pull_en, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   int          error_cnt = 0;
   int          samples_checked = 0;
   logic [31:0] d;
   logic [1:0]  r;
   always #5 core_clk = ~core_clk;
   ios_seq #(.POR_SHORT_NS(200), .ADD_NS(300), .CD_NS(CD_NS), .UM_NS(UM_NS)) ios_seq_inst (
      .core_clk, .rst, .clk_en(1'b1), .restart_request_n, .chain_enable_in_n,
      .io_weak_pull_disable, .busy_flag_n_o(), .busy_flag_n_oe, .busy_flag_n_i,
      .ready_release_o(), .ready_release_oe, .ready_release_i, .chain_enable_out_n,
      .startup_done, .user_mode, .io_weak_pull_en, .restart_pull_en(), .busy_pull_en(),
      .ready_pull_en(), .cfg_serial_clock_pull_en(), .cfg_data_pull_en(), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   ios_seq_board ios_seq_board_inst (.core_clk, .restart_hold, .busy_flag_n_oe,
      .ready_release_oe, .restart_request_n, .chain_enable_in_n, .busy_flag_n_i,
      .ready_release_i);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] b);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      b = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] b);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      b = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wait_startup;
      while (startup_done !== 1'b1) @(posedge core_clk);
      chk("ready_oe", 0, ready_release_oe);
      chk("chain_out_n", 0, chain_enable_out_n);
      chk("user_mode", 1, user_mode);
   endtask
   task complete_run;
      if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge core_clk);
      chk("busy_oe", 1, busy_flag_n_oe);
      chk("startup", 0, startup_done);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("io_pull", 1, io_weak_pull_en);
      wait_startup;
      // Pull enable follows user mode one edge later
      @(posedge core_clk);
      chk("io_pull", 0, io_weak_pull_en);
      // Read-only places must ignore writes; unmapped gives SLVERR
      axi_write(12'h004, 32'hFFFF_FFFF, r);
      chk("bresp", 2'h0, r);
      axi_write(12'h00C, 32'hFFFF_FFFF, r);
      chk("bresp", 2'h2, r);
      for (int i = 0; i < 4; i++) begin
         axi_read(RA[i], d, r);
         chk("rdata", RD[i], d & RM[i]);
         chk("rresp", RR[i], r);
      end
      restart_hold <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk("busy_oe", 1, busy_flag_n_oe);
      chk("ready_oe", 1, ready_release_oe);
      chk("startup", 0, startup_done);
      chk("io_pull", 1, io_weak_pull_en);
      io_weak_pull_disable <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("io_pull", 0, io_weak_pull_en);
      io_weak_pull_disable <= 1'b0;
      restart_hold <= 1'b0;
      wait_startup;
      axi_write(12'h000, 32'h0000_0001, r);
      chk("bresp", 2'h0, r);
      while (busy_flag_n_oe !== 1'b1) @(posedge core_clk);
      chk("startup", 0, startup_done);
      wait_startup;
      // Restart held across a reset: sequence waits past the delay
      rst <= 1'b1;
      restart_hold <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (40) @(posedge core_clk);
      chk("busy_oe", 1, busy_flag_n_oe);
      restart_hold <= 1'b0;
      wait_startup;
      complete_run;
   end
endmodule
